//--- verilog/monitor_sticky_map.svh
// Register offsets, field positions, reset values and widths of the monitor sticky status bank
`ifndef MONITOR_STICKY_MAP_SVH
`define MONITOR_STICKY_MAP_SVH

`define MSB_ADDR_W            16
`define MSB_DATA_W            8

`define MSB_REF_FAULT_6_OFS   16'h018c
`define MSB_REF_FAULT_7_OFS   16'h018d
`define MSB_REF_FAULT_8_OFS   16'h018e
`define MSB_REF_FAULT_9_OFS   16'h018f
`define MSB_LOOP_EVENT_0_OFS  16'h0196
`define MSB_LOOP_EVENT_1_OFS  16'h0197
`define MSB_IRQ_MASK_LO_OFS   16'h01f0
`define MSB_IRQ_MASK_HI_OFS   16'h01f1

`define MSB_REF_PERIOD_BIT    4
`define MSB_REF_GUARD_BIT     3
`define MSB_REF_COARSE_BIT    2
`define MSB_REF_SINGLE_BIT    1
`define MSB_REF_LOS_BIT       0
`define MSB_REF_USED_MASK     8'h1f

`define MSB_LOOP_SLOPE_BIT    7
`define MSB_LOOP_PMEM_BIT     6
`define MSB_LOOP_RANGE_BIT    5
`define MSB_LOOP_HOLD_BIT     1
`define MSB_LOOP_LOL_BIT      0
`define MSB_LOOP_USED_MASK    8'he3

`define MSB_LATCH_RESET       8'h00
`define MSB_MASK_RESET        8'h00
`define MSB_READ_IDLE         8'h00

`define MSB_NUM_REF           4
`define MSB_NUM_LOOP          2

`endif

//--- verilog/monitor_sticky_pkg.sv
// Types shared by the monitor sticky status bank
package monitor_sticky_pkg;

   typedef logic [7:0] byte_t;

   typedef struct packed {
      logic period;
      logic guard;
      logic coarse;
      logic single;
      logic los;
   } ref_events_s;

   typedef struct packed {
      logic slope;
      logic pmem;
      logic range;
      logic hold;
      logic lol;
   } loop_events_s;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } reg_req_s;

   typedef enum logic [1:0] {
      RD_IDLE,
      RD_VALID
   } read_phase_e;

endpackage : monitor_sticky_pkg

//--- verilog/sticky_byte.sv
// One 8-bit write-one-to-clear sticky latch with a fixed mask of implemented bits
`include "monitor_sticky_map.svh"

module sticky_byte #(
   parameter logic [7:0] USED_MASK = 8'hff
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [7:0] set_in,
   input  wire logic       clr_we,
   input  wire logic [7:0] clr_data,
   output      logic [7:0] value
);

   typedef struct packed {
      logic [7:0] latch_q;
   } state_s;

   state_s st_q;
   state_s st_d;

   always_comb begin
      st_d = st_q;
      if (clr_we) begin
         st_d.latch_q = st_q.latch_q & ~clr_data;
      end
      // Set after clear so a same-cycle event survives the acknowledge
      st_d.latch_q = (st_d.latch_q | set_in) & USED_MASK;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= '{latch_q: `MSB_LATCH_RESET};
      end else begin
         st_q <= st_d;
      end
   end

   assign value = st_q.latch_q;

endmodule : sticky_byte

//--- verilog/monitor_sticky_status_bank.sv
// Latched reference-fault and loop-event status bank with write-one-to-clear and interrupt
`include "monitor_sticky_map.svh"

module monitor_sticky_status_bank (
   input  wire logic                                                 CLK_SYS,
   input  wire logic                                                 RESET,
   input  wire logic [15:0]                                          REG_ADDR,
   input  wire logic [7:0]                                           REG_WDATA,
   input  wire logic                                                 REG_WR,
   input  wire logic                                                 REG_RD,
   output      logic [7:0]                                           REG_RDATA,
   input  wire monitor_sticky_pkg::ref_events_s  [`MSB_NUM_REF-1:0]  REF_EVENTS,
   input  wire monitor_sticky_pkg::loop_events_s [`MSB_NUM_LOOP-1:0] LOOP_EVENTS,
   output      logic                                                 IRQ
);

   typedef struct packed {
      logic [7:0]                      rdata_q;
      monitor_sticky_pkg::read_phase_e phase_q;
      logic [7:0]                      mask_lo_q;
      logic [7:0]                      mask_hi_q;
   } state_s;

   state_s st_q;
   state_s st_d;

   monitor_sticky_pkg::reg_req_s req;
   monitor_sticky_pkg::byte_t    ref_set   [`MSB_NUM_REF];
   monitor_sticky_pkg::byte_t    ref_val   [`MSB_NUM_REF];
   logic                         ref_we    [`MSB_NUM_REF];
   monitor_sticky_pkg::byte_t    loop_set  [`MSB_NUM_LOOP];
   monitor_sticky_pkg::byte_t    loop_val  [`MSB_NUM_LOOP];
   logic                         loop_we   [`MSB_NUM_LOOP];
   logic [7:0]                   ref_any;
   logic [7:0]                   loop_any;

   assign req.addr  = REG_ADDR;
   assign req.wdata = REG_WDATA;
   assign req.wr    = REG_WR;
   assign req.rd    = REG_RD;

   // Reference fault latches, one per monitored input
   for (genvar i = 0; i < `MSB_NUM_REF; i++) begin : g_ref
      always_comb begin
         ref_set[i]                      = `MSB_LATCH_RESET;
         ref_set[i][`MSB_REF_PERIOD_BIT] = REF_EVENTS[i].period;
         ref_set[i][`MSB_REF_GUARD_BIT]  = REF_EVENTS[i].guard;
         ref_set[i][`MSB_REF_COARSE_BIT] = REF_EVENTS[i].coarse;
         ref_set[i][`MSB_REF_SINGLE_BIT] = REF_EVENTS[i].single;
         ref_set[i][`MSB_REF_LOS_BIT]    = REF_EVENTS[i].los;
      end

      // Consecutive offsets from reference 6 upward
      assign ref_we[i] = req.wr && (req.addr == `MSB_REF_FAULT_6_OFS + 16'(i));

      sticky_byte #(
         .USED_MASK (`MSB_REF_USED_MASK)
      ) u_ref (
         .clk      (CLK_SYS),
         .rst      (RESET),
         .set_in   (ref_set[i]),
         .clr_we   (ref_we[i]),
         .clr_data (req.wdata),
         .value    (ref_val[i])
      );
   end

   // Loop event latches, one per digital loop
   for (genvar j = 0; j < `MSB_NUM_LOOP; j++) begin : g_loop
      always_comb begin
         loop_set[j]                      = `MSB_LATCH_RESET;
         loop_set[j][`MSB_LOOP_SLOPE_BIT] = LOOP_EVENTS[j].slope;
         loop_set[j][`MSB_LOOP_PMEM_BIT]  = LOOP_EVENTS[j].pmem;
         loop_set[j][`MSB_LOOP_RANGE_BIT] = LOOP_EVENTS[j].range;
         loop_set[j][`MSB_LOOP_HOLD_BIT]  = LOOP_EVENTS[j].hold;
         loop_set[j][`MSB_LOOP_LOL_BIT]   = LOOP_EVENTS[j].lol;
      end

      assign loop_we[j] = req.wr && (req.addr == `MSB_LOOP_EVENT_0_OFS + 16'(j));

      sticky_byte #(
         .USED_MASK (`MSB_LOOP_USED_MASK)
      ) u_loop (
         .clk      (CLK_SYS),
         .rst      (RESET),
         .set_in   (loop_set[j]),
         .clr_we   (loop_we[j]),
         .clr_data (req.wdata),
         .value    (loop_val[j])
      );
   end

   // Register slave: writes take effect at the strobe edge, reads answer one cycle later
   always_comb begin
      st_d         = st_q;
      st_d.rdata_q = `MSB_READ_IDLE;
      st_d.phase_q = monitor_sticky_pkg::RD_IDLE;

      if (req.wr) begin
         case (req.addr)
            `MSB_IRQ_MASK_LO_OFS: begin
               st_d.mask_lo_q = req.wdata;
            end
            `MSB_IRQ_MASK_HI_OFS: begin
               st_d.mask_hi_q = req.wdata;
            end
            default: begin
               st_d.mask_lo_q = st_q.mask_lo_q;
            end
         endcase
      end

      if (req.rd) begin
         st_d.phase_q = monitor_sticky_pkg::RD_VALID;
         // Unmapped addresses read as zero rather than stalling the master
         case (req.addr)
            `MSB_REF_FAULT_6_OFS:  st_d.rdata_q = ref_val[0];
            `MSB_REF_FAULT_7_OFS:  st_d.rdata_q = ref_val[1];
            `MSB_REF_FAULT_8_OFS:  st_d.rdata_q = ref_val[2];
            `MSB_REF_FAULT_9_OFS:  st_d.rdata_q = ref_val[3];
            `MSB_LOOP_EVENT_0_OFS: st_d.rdata_q = loop_val[0];
            `MSB_LOOP_EVENT_1_OFS: st_d.rdata_q = loop_val[1];
            `MSB_IRQ_MASK_LO_OFS:  st_d.rdata_q = st_q.mask_lo_q;
            `MSB_IRQ_MASK_HI_OFS:  st_d.rdata_q = st_q.mask_hi_q;
            default:               st_d.rdata_q = `MSB_READ_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         st_q <= '{rdata_q:   `MSB_READ_IDLE,
                   phase_q:   monitor_sticky_pkg::RD_IDLE,
                   mask_lo_q: `MSB_MASK_RESET,
                   mask_hi_q: `MSB_MASK_RESET};
      end else begin
         st_q <= st_d;
      end
   end

   // Read data stand only in the cycle after the strobe
   assign REG_RDATA = (st_q.phase_q == monitor_sticky_pkg::RD_VALID) ? st_q.rdata_q : `MSB_READ_IDLE;

   // Low mask byte: bit n gates any flag of reference latch n; high byte: bit n gates loop latch n
   always_comb begin
      ref_any  = 8'h00;
      loop_any = 8'h00;
      for (int k = 0; k < `MSB_NUM_REF; k++) begin
         ref_any[k] = |ref_val[k];
      end
      for (int k = 0; k < `MSB_NUM_LOOP; k++) begin
         loop_any[k] = |loop_val[k];
      end
   end

   assign IRQ = |(ref_any & st_q.mask_lo_q) | |(loop_any & st_q.mask_hi_q);

endmodule : monitor_sticky_status_bank

//--- verification/monitor_sticky_status_bank_monitor.sv
// Port-level checker for the monitor sticky status bank
module monitor_sticky_status_bank_chk (
   input wire logic                                    CLK_SYS,
   input wire logic                                    RESET,
   input wire logic [15:0]                             REG_ADDR,
   input wire logic [7:0]                              REG_WDATA,
   input wire logic                                    REG_WR,
   input wire logic                                    REG_RD,
   input wire logic [7:0]                              REG_RDATA,
   input wire monitor_sticky_pkg::ref_events_s  [3:0]  REF_EVENTS,
   input wire monitor_sticky_pkg::loop_events_s [1:0]  LOOP_EVENTS,
   input wire logic                                    IRQ
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RESET);
   // Loop flags sit at 7,6,5 and 1,0 of the byte
   function automatic logic [7:0] lmap(input logic [4:0] e);
      return {e[4:2], 3'h0, e[1:0]};
   endfunction : lmap
   sequence s_rd(logic [15:0] a);
      REG_RD && REG_ADDR == a;
   endsequence
   sequence s_clr;
      REG_WR && REG_ADDR == 16'h018c && REG_WDATA[4:0] == 5'h1f && REF_EVENTS[0] == 5'h00;
   endsequence
   property p_ref_set;
      REF_EVENTS[0] != 5'h00 ##1 s_rd(16'h018c) |=> (REG_RDATA[4:0] & $past(REF_EVENTS[0], 2)) == $past(REF_EVENTS[0], 2);
   endproperty
   property p_ref_rsv;
      REG_RD && REG_ADDR[15:2] == 14'h0063 |=> REG_RDATA[7:5] == 3'h0;
   endproperty
   property p_loop0_set;
      LOOP_EVENTS[0] != 5'h00 ##1 s_rd(16'h0196) |=> (REG_RDATA & lmap($past(LOOP_EVENTS[0], 2))) == lmap($past(LOOP_EVENTS[0], 2));
   endproperty
   property p_loop1_set;
      LOOP_EVENTS[1] != 5'h00 ##1 s_rd(16'h0197) |=> (REG_RDATA & lmap($past(LOOP_EVENTS[1], 2))) == lmap($past(LOOP_EVENTS[1], 2));
   endproperty
   property p_loop_rsv;
      REG_RD && REG_ADDR[15:1] == 15'h00cb |=> REG_RDATA[4:2] == 3'h0;
   endproperty
   property p_w1c;
      s_clr ##1 s_rd(16'h018c) |=> REG_RDATA == 8'h00;
   endproperty
   property p_set_wins;
      REG_WR && REG_ADDR == 16'h018c && REG_WDATA[0] && REF_EVENTS[0].los ##1 s_rd(16'h018c) |=> REG_RDATA[0];
   endproperty
   property p_unmapped;
      s_rd(16'h0190) |=> REG_RDATA == 8'h00;
   endproperty
   property p_rdata_idle;
      !REG_RD |=> REG_RDATA == 8'h00;
   endproperty
   a_ref_set: assert property (p_ref_set) else $error("ref latch lost an event");
   a_ref_rsv: assert property (p_ref_rsv) else $error("ref reserved bits set");
   a_loop0_set: assert property (p_loop0_set) else $error("loop 0 latch lost an event");
   a_loop1_set: assert property (p_loop1_set) else $error("loop 1 latch lost an event");
   a_loop_rsv: assert property (p_loop_rsv) else $error("loop reserved bits set");
   a_w1c: assert property (p_w1c) else $error("write one did not clear");
   a_set_wins: assert property (p_set_wins) else $error("clear beat a same-cycle event");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
endmodule : monitor_sticky_status_bank_chk

//--- verification/monitor_sticky_status_bank_tb.sv
// Self-checking bench for the monitor sticky status bank
module monitor_sticky_status_bank_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                                   clk_sys, reset, reg_wr, reg_rd, irq;
   logic [15:0]                            reg_addr;
   logic [7:0]                             reg_wdata, reg_rdata;
   monitor_sticky_pkg::ref_events_s  [3:0] ref_ev;
   monitor_sticky_pkg::loop_events_s [1:0] loop_ev;
   int                                     error_cnt = 0;
   int                                     cmp_count = 0;
   logic [15:0] adr [8] = '{16'h018c, 16'h018d, 16'h018e, 16'h018f, 16'h0196, 16'h0197, 16'h01f0, 16'h01f1};
   monitor_sticky_status_bank dut (.CLK_SYS(clk_sys), .RESET(reset), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REF_EVENTS(ref_ev), .LOOP_EVENTS(loop_ev), .IRQ(irq));
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task test_done;
      $display("errors=%0d compares=%0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : test_done
   // Returns on the write edge so a read can follow with no gap
   task wr(input logic [15:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [15:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
      @(posedge clk_sys);
   endtask : rd
   // Looks at the settled level mid-cycle and hands back on a rising edge
   task irq_chk(input logic [7:0] e);
      @(negedge clk_sys);
      chk({7'h00, irq}, e);
      @(posedge clk_sys);
   endtask : irq_chk
   task ev(input logic [19:0] r, input logic [9:0] l);
      ref_ev <= r;
      loop_ev <= l;
      @(posedge clk_sys);
      ref_ev <= '0;
      loop_ev <= '0;
   endtask : ev
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      test_done();
   end
   initial begin
      reset = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 16'h0000;
      reg_wdata = 8'h00;
      ref_ev = '0;
      loop_ev = '0;
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      for (int i = 0; i < 8; i++) rd(adr[i], 8'h00);
      wr(16'h0190, 8'hff);
      rd(16'h0190, 8'h00);
      for (int i = 0; i < 4; i++) for (int b = 0; b < 5; b++) begin
         ev(20'(1 << (5 * i + b)), 10'h000);
         rd(adr[i], 8'(1 << b));
         wr(adr[i], 8'hff);
         rd(adr[i], 8'h00);
      end
      for (int j = 0; j < 2; j++) for (int b = 0; b < 5; b++) begin
         ev(20'h00000, 10'(1 << (5 * j + b)));
         rd(adr[4 + j], 8'(b > 1 ? 1 << (b + 3) : 1 << b));
         wr(adr[4 + j], 8'hff);
         rd(adr[4 + j], 8'h00);
      end
      ev(20'h0001f, 10'h000);
      wr(16'h018c, 8'h01);
      rd(16'h018c, 8'h1e);
      ref_ev <= 20'h00001;
      wr(16'h018c, 8'h01);
      ref_ev <= '0;
      rd(16'h018c, 8'h1f);
      irq_chk(8'h00);
      wr(16'h01f0, 8'h01);
      irq_chk(8'h01);
      rd(16'h01f0, 8'h01);
      wr(16'h018c, 8'hff);
      irq_chk(8'h00);
      wr(16'h01f1, 8'h02);
      ev(20'h00000, 10'h020);
      irq_chk(8'h01);
      wr(16'h0197, 8'h01);
      irq_chk(8'h00);
      // Reset must wipe latches that are set mid-run
      ev(20'hfffff, 10'h3ff);
      reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      for (int i = 0; i < 8; i++) rd(adr[i], 8'h00);
      test_done();
   end
endmodule : monitor_sticky_status_bank_tb
bind monitor_sticky_status_bank monitor_sticky_status_bank_chk chk_i (.CLK_SYS(CLK_SYS), .RESET(RESET),
   .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
   .REF_EVENTS(REF_EVENTS), .LOOP_EVENTS(LOOP_EVENTS), .IRQ(IRQ));
